/* csg_defines.vh */
// Register map, field positions, reset values and timing figures of the clock source generator
`ifndef CSG_DEFINES_VH
`define CSG_DEFINES_VH
// Register byte offsets
`define CSG_OFS_OSC_CTRL    8'h00
`define CSG_OFS_INT_OSC_CTRL 8'h04
`define CSG_OFS_CORE_CLK    8'h08
`define CSG_OFS_PERIPH_CLK  8'h0C
`define CSG_OFS_CLK_OUT_CTRL 8'h10
`define CSG_OFS_WAIT_CTRL   8'h14
`define CSG_OFS_IRQ_STATUS  8'h18
`define CSG_OFS_IRQ_ENABLE  8'h1C
`define CSG_OFS_IRQ_CLEAR   8'h20
`define CSG_OFS_SRC_STATE   8'h24
// Source codes, also bit index in source vectors
`define CSG_SRC_INT         2'h0
`define CSG_SRC_LSC         2'h1
`define CSG_SRC_HSR         2'h2
`define CSG_SRC_EXT         2'h3
// Reset values
`define CSG_RST_EN          4'h1
`define CSG_RST_FREQ        3'h4
// Internal oscillator wait in its own clock ticks
`define CSG_INT_OSC_WAIT    18'h0_0010
// Event bit of the low-speed stop detector
`define CSG_EV_STOP         4
// Pclk period and low-speed stop timeout, in ns
`define CSG_CLK_NS          25
`define CSG_STOP_NS         200000
`endif

/* csg_stab_wait.v */
// Oscillation stabilization wait counter for one clock source
`timescale 1ns/100ps
`default_nettype none
module csg_stab_wait (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        enable,
	input  wire        src_tick,
	input  wire [17:0] wait_cnt,
	output reg         stable_reg,
	output reg         done_reg
);
	reg [17:0] cnt_reg;

	// Count source ticks from enable; zero wait means pass at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg    <= 18'h0_0000;
			stable_reg <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (!enable) begin
				cnt_reg    <= 18'h0_0000; // Every restart pays the full wait
				stable_reg <= 1'b0;
			end else if (!stable_reg) begin
				if (wait_cnt == 18'h0_0000) begin
					stable_reg <= 1'b1;
					done_reg   <= 1'b1;
				end else if (src_tick) begin
					if (cnt_reg + 18'h0_0001 == wait_cnt) begin
						stable_reg <= 1'b1;
						done_reg   <= 1'b1;
					end
					cnt_reg <= cnt_reg + 18'h0_0001;
				end
			end
		end
	end
endmodule // csg_stab_wait
`default_nettype wire

/* csg_clock_source_generator.v */
// Clock source generator: source enables, stabilization, clock selection, sleep control, clock output
`timescale 1ns/100ps
`default_nettype none
`include "csg_defines.vh"
module csg_clock_source_generator #(
	parameter STOP_CYC      = `CSG_STOP_NS / `CSG_CLK_NS,
	parameter LSC_WAIT_BASE = 16384,
	parameter HSR_WAIT_BASE = 1024
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_reg,
	output reg         pready_reg,
	output reg         pslverr_reg,
	input  wire        sleep_mode,
	input  wire        internal_osc_tick,
	input  wire        low_speed_crystal_osc_tick,
	input  wire        high_speed_resonator_osc_tick,
	input  wire        external_clock_input_tick,
	output reg  [3:0]  source_enable_reg,
	output reg         lsc_boost_reg,
	output reg  [2:0]  internal_osc_freq_select_reg,
	output reg         core_bus_clock_en_reg,
	output reg         periph_clock_en_reg,
	output reg         clock_output_pin_reg,
	output reg         irq_reg
);
	// Software state
	reg [3:0]  en_reg;
	reg [3:0]  slpc_reg;
	reg        boost_en_reg;
	reg [1:0]  core_src_reg;
	reg [1:0]  core_div_reg;
	reg [1:0]  wup_src_reg;
	reg [1:0]  wup_div_reg;
	reg        wup_md_reg;
	reg [1:0]  per_src_reg;
	reg [1:0]  per_div_reg;
	reg [1:0]  fo_src_reg;
	reg [2:0]  fo_div_reg;
	reg        fo_en_reg;
	reg [1:0]  lsw_reg;
	reg [1:0]  hsw_reg;
	reg [4:0]  status_reg;
	reg [4:0]  ien_reg;
	reg [3:0]  saved_en_reg;
	reg        sleep_d_reg;
	reg        restart_reg;
	reg [15:0] stop_cnt_reg;
	reg [6:0]  core_cnt_reg;
	reg [6:0]  per_cnt_reg;
	reg [6:0]  fo_cnt_reg;
	reg [31:0] rd_next;
	reg        hit_next;

	wire [3:0]  tick;
	wire [3:0]  stable;
	wire [3:0]  done;
	wire [17:0] wait_tab [0:3];
	wire        wr_acc;
	wire        sleep_in;
	wire        sleep_out;
	wire [4:0]  irq_clr;

	assign tick = {external_clock_input_tick, high_speed_resonator_osc_tick,
		low_speed_crystal_osc_tick, internal_osc_tick};
	assign wr_acc = psel & penable & pready_reg & pwrite;
	assign sleep_in = sleep_mode & ~sleep_d_reg;
	assign sleep_out = ~sleep_mode & sleep_d_reg;
	assign irq_clr = (wr_acc && paddr == `CSG_OFS_IRQ_CLEAR) ? pwdata[4:0] : 5'h00;

	// Wait lengths in source ticks; oscillator settings scale a base
	assign wait_tab[`CSG_SRC_INT] = `CSG_INT_OSC_WAIT;
	assign wait_tab[`CSG_SRC_LSC] = LSC_WAIT_BASE[17:0] << lsw_reg;
	assign wait_tab[`CSG_SRC_HSR] = HSR_WAIT_BASE[17:0] << hsw_reg;
	assign wait_tab[`CSG_SRC_EXT] = 18'h0_0000;

	// A divided tick: one in 2**code of the source ticks
	function div_hit;
		input [6:0] cnt;
		input [2:0] code;
		begin
			div_hit = ((cnt & ((7'h01 << code) - 7'h01)) == 7'h00);
		end
	endfunction

	// Tick of a source, passed only after its wait is over
	function src_gate;
		input [1:0] src;
		input [3:0] t;
		input [3:0] s;
		begin
			src_gate = t[src] & s[src];
		end
	endfunction

	// One wait counter per source; a stop restart drops the enable for one cycle
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_wait
			csg_stab_wait u_wait (
				.pclk       (pclk),
				.presetn    (presetn),
				.enable     (en_reg[gi] & ~(restart_reg & (gi == `CSG_SRC_LSC))),
				.src_tick   (tick[gi]),
				.wait_cnt   (wait_tab[gi]),
				.stable_reg (stable[gi]),
				.done_reg   (done[gi])
			);
		end
	endgenerate

	// Read mux and address decode
	always @* begin
		rd_next = 32'h0000_0000;
		hit_next = 1'b1;
		case (paddr)
			`CSG_OFS_OSC_CTRL:   rd_next = {23'h00_0000, boost_en_reg, slpc_reg, en_reg};
			`CSG_OFS_INT_OSC_CTRL: rd_next = {29'h0000_0000, internal_osc_freq_select_reg};
			`CSG_OFS_CORE_CLK:   rd_next = {23'h00_0000, wup_md_reg, wup_div_reg, wup_src_reg,
				core_div_reg, core_src_reg};
			`CSG_OFS_PERIPH_CLK: rd_next = {28'h000_0000, per_div_reg, per_src_reg};
			`CSG_OFS_CLK_OUT_CTRL: rd_next = {26'h000_0000, fo_en_reg, fo_div_reg, fo_src_reg};
			`CSG_OFS_WAIT_CTRL:  rd_next = {28'h000_0000, hsw_reg, lsw_reg};
			`CSG_OFS_IRQ_STATUS: rd_next = {27'h000_0000, status_reg};
			`CSG_OFS_IRQ_ENABLE: rd_next = {27'h000_0000, ien_reg};
			`CSG_OFS_IRQ_CLEAR:  rd_next = 32'h0000_0000; // Write-only
			`CSG_OFS_SRC_STATE:  rd_next = {23'h00_0000, sleep_d_reg, stable, source_enable_reg};
			default:             hit_next = 1'b0;
		endcase
	end

	// APB slave: one access cycle, answer prepared at setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= psel & ~penable;
			pslverr_reg <= psel & ~penable & ~hit_next;
			if (psel && !penable && !pwrite)
				prdata_reg <= rd_next;
		end
	end

	// Control registers, with sleep entry and exit handling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= `CSG_RST_EN;
			slpc_reg <= 4'h0;
			boost_en_reg <= 1'b0;
			internal_osc_freq_select_reg <= `CSG_RST_FREQ;
			core_src_reg <= `CSG_SRC_INT;
			core_div_reg <= 2'h0;
			wup_src_reg <= `CSG_SRC_INT;
			wup_div_reg <= 2'h0;
			wup_md_reg <= 1'b0;
			per_src_reg <= `CSG_SRC_INT;
			per_div_reg <= 2'h0;
			fo_src_reg <= `CSG_SRC_INT;
			fo_div_reg <= 3'h0;
			fo_en_reg <= 1'b0;
			lsw_reg <= 2'h0;
			hsw_reg <= 2'h0;
			ien_reg <= 5'h00;
			saved_en_reg <= `CSG_RST_EN;
			sleep_d_reg <= 1'b0;
		end else begin
			sleep_d_reg <= sleep_mode;
			if (sleep_in) begin
				saved_en_reg <= en_reg;
				en_reg <= en_reg & ~slpc_reg;
			end else if (sleep_out) begin
				if (wup_md_reg) begin
					// Restore stopped sources and start the wake-up clock
					en_reg <= saved_en_reg | (4'h1 << wup_src_reg);
					core_src_reg <= wup_src_reg;
					core_div_reg <= wup_div_reg;
				end else begin
					// Keep states, but never leave the core source stopped
					en_reg <= en_reg | (4'h1 << core_src_reg);
				end
			end else if (wr_acc) begin
				case (paddr)
					`CSG_OFS_OSC_CTRL: begin
						en_reg <= pwdata[3:0];
						slpc_reg <= pwdata[7:4];
						boost_en_reg <= pwdata[8];
					end
					`CSG_OFS_INT_OSC_CTRL: internal_osc_freq_select_reg <= pwdata[2:0];
					`CSG_OFS_CORE_CLK: begin
						core_src_reg <= pwdata[1:0];
						core_div_reg <= pwdata[3:2];
						wup_src_reg <= pwdata[5:4];
						wup_div_reg <= pwdata[7:6];
						wup_md_reg <= pwdata[8];
					end
					`CSG_OFS_PERIPH_CLK: begin
						per_src_reg <= pwdata[1:0];
						per_div_reg <= pwdata[3:2];
					end
					`CSG_OFS_CLK_OUT_CTRL: begin
						fo_src_reg <= pwdata[1:0];
						fo_div_reg <= pwdata[4:2];
						fo_en_reg <= pwdata[5];
					end
					`CSG_OFS_WAIT_CTRL: begin
						lsw_reg <= pwdata[1:0];
						hsw_reg <= pwdata[3:2];
					end
					`CSG_OFS_IRQ_ENABLE: ien_reg <= pwdata[4:0];
					default: ien_reg <= ien_reg;
				endcase
			end
		end
	end

	// Enables to the analog cells; boost only during the startup wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_enable_reg <= `CSG_RST_EN;
			lsc_boost_reg <= 1'b0;
		end else begin
			source_enable_reg <= en_reg & ~{2'h0, restart_reg, 1'b0};
			lsc_boost_reg <= boost_en_reg & en_reg[`CSG_SRC_LSC] & ~stable[`CSG_SRC_LSC];
		end
	end

	// Low-speed stop detector: no tick for the timeout restarts the oscillator
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_cnt_reg <= 16'h0000;
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= 1'b0;
			if (!stable[`CSG_SRC_LSC] || low_speed_crystal_osc_tick || restart_reg) begin
				stop_cnt_reg <= 16'h0000;
			end else if (stop_cnt_reg == STOP_CYC[15:0] - 16'h0001) begin
				stop_cnt_reg <= 16'h0000;
				restart_reg <= 1'b1;
			end else begin
				stop_cnt_reg <= stop_cnt_reg + 16'h0001;
			end
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 5'h00;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~irq_clr) | {restart_reg, done};
			irq_reg <= |(status_reg & ien_reg);
		end
	end

	// Core/bus and peripheral clock enables from selected, stable, divided ticks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_cnt_reg <= 7'h00;
			per_cnt_reg <= 7'h00;
			core_bus_clock_en_reg <= 1'b0;
			periph_clock_en_reg <= 1'b0;
		end else begin
			core_bus_clock_en_reg <= 1'b0;
			periph_clock_en_reg <= 1'b0;
			if (src_gate(core_src_reg, tick, stable)) begin
				core_cnt_reg <= core_cnt_reg + 7'h01;
				core_bus_clock_en_reg <= div_hit(core_cnt_reg, {1'b0, core_div_reg});
			end
			if (src_gate(per_src_reg, tick, stable)) begin
				per_cnt_reg <= per_cnt_reg + 7'h01;
				periph_clock_en_reg <= div_hit(per_cnt_reg, {1'b0, per_div_reg});
			end
		end
	end

	// Clock output pin toggles on divided ticks; low while disabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fo_cnt_reg <= 7'h00;
			clock_output_pin_reg <= 1'b0;
		end else if (!fo_en_reg) begin
			fo_cnt_reg <= 7'h00;
			clock_output_pin_reg <= 1'b0;
		end else if (src_gate(fo_src_reg, tick, stable)) begin
			fo_cnt_reg <= fo_cnt_reg + 7'h01;
			if (div_hit(fo_cnt_reg, fo_div_reg))
				clock_output_pin_reg <= ~clock_output_pin_reg;
		end
	end
endmodule // csg_clock_source_generator
`default_nettype wire

/* csg_osc_model.sv */
// Behavioural oscillator cells and external clock source for the generator bench
`timescale 1ns/100ps
`default_nettype none
module csg_osc_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] source_enable_reg,
	input  wire logic       lsc_halt,
	output var  logic       internal_osc_tick,
	output var  logic       low_speed_crystal_osc_tick,
	output var  logic       high_speed_resonator_osc_tick,
	output var  logic       external_clock_input_tick
);
	localparam int PER[4] = '{2, 5, 3, 2}; // External edges every two cycles stay under its limit
	int         cnt[4];
	logic [3:0] t;

	// Tick vector onto the named pins
	assign {external_clock_input_tick, high_speed_resonator_osc_tick} = t[3:2];
	assign {low_speed_crystal_osc_tick, internal_osc_tick} = t[1:0];

	// Disabled cells stay silent; the external source already runs before it is enabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '{default: 0};
			t   <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				cnt[i] <= (cnt[i] + 1) % PER[i];
				t[i]   <= cnt[i] == 0 && (source_enable_reg[i] || i == 3) && !(i == 1 && lsc_halt);
			end
		end
	end
endmodule // csg_osc_model
`default_nettype wire

/* csg_clock_source_generator_sva.sv */
// Port-level assertions of the clock source generator
`timescale 1ns/100ps
`default_nettype none
`include "csg_defines.vh"
module csg_gen_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready_reg,
	input wire logic        sleep_mode,
	input wire logic        internal_osc_tick,
	input wire logic [3:0]  source_enable_reg,
	input wire logic        lsc_boost_reg,
	input wire logic [2:0]  internal_osc_freq_select_reg,
	input wire logic        core_bus_clock_en_reg,
	input wire logic        clock_output_pin_reg,
	input wire logic        irq_reg
);
	logic       wr, pin_en_q, boost_q, wmd_q, slp_d;
	logic [3:0] stop_q;
	logic [1:0] src_q, wsrc_q;
	logic [2:0] freq_q;
	logic [4:0] boot_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel & penable & pready_reg & pwrite;

	// Shadow of written fields, since the ports alone do not show the settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pin_en_q, boost_q, wmd_q, slp_d, stop_q, src_q, wsrc_q} <= '0;
			freq_q   <= `CSG_RST_FREQ;
			boot_cnt <= 5'h00;
		end else begin
			slp_d <= sleep_mode;
			if (wr && paddr == `CSG_OFS_OSC_CTRL)
				{boost_q, stop_q} <= pwdata[8:4];
			if (wr && paddr == `CSG_OFS_INT_OSC_CTRL)
				freq_q <= pwdata[2:0];
			if (wr && paddr == `CSG_OFS_CLK_OUT_CTRL)
				pin_en_q <= pwdata[5];
			if (wr && paddr == `CSG_OFS_CORE_CLK)
				{wmd_q, wsrc_q, src_q} <= {pwdata[8], pwdata[5:4], pwdata[1:0]};
			else if (slp_d && !sleep_mode && wmd_q)
				src_q <= wsrc_q;
			// Saturates at sixteen so the boot window stays known
			if (internal_osc_tick && source_enable_reg[0] && boot_cnt < 5'h10)
				boot_cnt <= boot_cnt + 5'h01;
		end
	end

	a_boot_state: assert property ($rose(presetn) |-> source_enable_reg == 4'h1 && !irq_reg)
		else $error("boot source state wrong");
	a_freq_field: assert property (internal_osc_freq_select_reg == freq_q)
		else $error("frequency select differs from written code");
	a_sleep_stop: assert property ($rose(sleep_mode) |-> ##[1:2] (source_enable_reg & stop_q) == 4'h0)
		else $error("source marked to stop still enabled in sleep");
	a_wake_source: assert property ($fell(sleep_mode) |-> ##[1:2] source_enable_reg[wmd_q ? wsrc_q : src_q])
		else $error("wake core source not enabled");
	// Assist and cell enable leave the same edge, so the enable is compared in the same cycle
	a_boost_window: assert property (lsc_boost_reg |-> $past(boost_q) && source_enable_reg[1])
		else $error("startup assist active outside its window");
	a_pin_quiet: assert property (!pin_en_q && !$past(pin_en_q) |-> !clock_output_pin_reg)
		else $error("clock output pin not low while disabled");
	a_pin_needs_en: assert property ($rose(clock_output_pin_reg) |-> pin_en_q || $past(pin_en_q))
		else $error("clock output pin toggled without enable");
	a_boot_wait: assert property (boot_cnt < 5'h10 |-> !core_bus_clock_en_reg)
		else $error("core clock supplied before internal wait ended");
endmodule // csg_gen_sva
bind csg_clock_source_generator csg_gen_sva csg_gen_sva_i (.*);
`default_nettype wire

/* test_csg_clock_source_generator.sv */
// Self-checking bench of the clock source generator against a register model
`timescale 1ns/100ps
`default_nettype none
`include "csg_defines.vh"
module test_csg_clock_source_generator;
	logic        pclk, presetn, psel, penable, pwrite, sleep_mode, lsc_halt, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata_reg, rd, seed;
	logic        pready_reg, pslverr_reg, lsc_boost_reg, core_bus_clock_en_reg, periph_clock_en_reg;
	logic        clock_output_pin_reg, irq_reg, internal_osc_tick, low_speed_crystal_osc_tick;
	logic        high_speed_resonator_osc_tick, external_clock_input_tick;
	logic [3:0]  source_enable_reg;
	logic [2:0]  internal_osc_freq_select_reg;
	int          fail_count, num_checks, n, np, nc;
	int          mdl[int], msk[int];

	csg_clock_source_generator #(.STOP_CYC(50), .LSC_WAIT_BASE(4), .HSR_WAIT_BASE(4))
		csg_clock_source_generator_i (.*);
	csg_osc_model csg_osc_model_i (.*);

	// Clock at 40 MHz
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready_reg !== 1'b1 && k < 16);
		if (k >= 16)
			fail_count++;
		rd = prdata_reg;
		er = pslverr_reg;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input int a, input logic [31:0] d);
		apb(1'b1, a[7:0], d);
		if (msk.exists(a))
			mdl[a] = d & msk[a];
	endtask
	task automatic rdc(input int a, input logic [31:0] e);
		apb(1'b0, a[7:0], 32'h0000_0000);
		chk(rd, e);
	endtask
	// Counts pin edges and clock enable pulses over c cycles
	// The edge that applies a new setting still acts on the old one, so it is let pass first
	task automatic watch(input int c);
		logic p;
		@(posedge pclk);
		p = clock_output_pin_reg;
		n = 0;
		np = 0;
		nc = 0;
		repeat (c) begin
			@(posedge pclk);
			n += (clock_output_pin_reg !== p);
			np += (periph_clock_en_reg === 1'b1);
			nc += (core_bus_clock_en_reg === 1'b1);
			p = clock_output_pin_reg;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cuts a hang short; the tests need about eleven hundred cycles
	initial begin
		repeat (30000) @(posedge pclk);
		fail_count++;
		print_verdict();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, sleep_mode, lsc_halt} = '0;
		presetn = 1'b0;
		seed = 32'hc37d_dc53;
		fail_count = 0;
		num_checks = 0;
		mdl = '{`CSG_OFS_OSC_CTRL: 4'h1, `CSG_OFS_INT_OSC_CTRL: 4'h4, `CSG_OFS_CORE_CLK: 0, `CSG_OFS_PERIPH_CLK: 0,
			`CSG_OFS_CLK_OUT_CTRL: 0, `CSG_OFS_WAIT_CTRL: 0, `CSG_OFS_IRQ_ENABLE: 0};
		msk = '{`CSG_OFS_OSC_CTRL: 12'h1ff, `CSG_OFS_INT_OSC_CTRL: 4'h7, `CSG_OFS_CORE_CLK: 12'h1ff,
			`CSG_OFS_PERIPH_CLK: 4'hf, `CSG_OFS_CLK_OUT_CTRL: 8'h3f, `CSG_OFS_WAIT_CTRL: 4'hf,
			`CSG_OFS_IRQ_ENABLE: 8'h1f};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		foreach (mdl[a])
			rdc(a, mdl[a]);
		rdc(`CSG_OFS_SRC_STATE, 32'h0000_0011);
		for (int d = 0; d < 4; d++) begin
			wr(`CSG_OFS_PERIPH_CLK, d << 2);
			watch(64);
			chk(np, 32 >> d);
			chk(nc, 32);
		end
		wr(`CSG_OFS_PERIPH_CLK, 32'h0000_0002);
		watch(20);
		chk(np, 0);
		$display("boot and divider test done");
		// Random settings in every read-write register, then an unmapped place
		repeat (4) begin
			foreach (mdl[a])
				wr(a, xs());
			foreach (mdl[a])
				rdc(a, mdl[a]);
			chk(internal_osc_freq_select_reg, mdl[`CSG_OFS_INT_OSC_CTRL]);
		end
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk(rd, 0);
		chk(er, 1);
		foreach (mdl[a])
			wr(a, a == 0);
		repeat (40) @(posedge pclk);
		wr(`CSG_OFS_IRQ_CLEAR, 32'h0000_001f);
		rdc(`CSG_OFS_IRQ_STATUS, 0);
		$display("register test done");
		// External input is stable at once while the crystal waits; interrupt masked and cleared
		wr(`CSG_OFS_IRQ_ENABLE, 32'h0000_0008);
		wr(`CSG_OFS_OSC_CTRL, 32'h0000_010b);
		rdc(`CSG_OFS_SRC_STATE, 32'h0000_009b);
		chk(lsc_boost_reg, 1);
		// Interrupt trails the status bit by one more edge
		@(posedge pclk);
		chk(irq_reg, 1);
		wr(`CSG_OFS_IRQ_ENABLE, 0);
		repeat (2) @(posedge pclk);
		chk(irq_reg, 0);
		wr(`CSG_OFS_IRQ_ENABLE, 32'h0000_0018);
		wr(`CSG_OFS_IRQ_CLEAR, 32'h0000_0008);
		repeat (2) @(posedge pclk);
		chk(irq_reg, 0);
		repeat (40) @(posedge pclk);
		rdc(`CSG_OFS_SRC_STATE, 32'h0000_00bb);
		chk(lsc_boost_reg, 0);
		rdc(`CSG_OFS_IRQ_STATUS, 32'h0000_0002);
		$display("stabilization test done");
		// Crystal stops; the detector restarts it and flags the event
		lsc_halt <= 1'b1;
		repeat (60) @(posedge pclk);
		lsc_halt <= 1'b0;
		repeat (40) @(posedge pclk);
		chk(irq_reg, 1);
		rdc(`CSG_OFS_IRQ_STATUS, 32'h0000_0012);
		wr(`CSG_OFS_IRQ_CLEAR, 32'h0000_001f);
		rdc(`CSG_OFS_IRQ_STATUS, 0);
		chk(irq_reg, 0);
		$display("stop detector test done");
		// Sleep stops marked sources; wake keeps states, then restores them and switches the core
		for (int m = 0; m < 2; m++) begin
			wr(`CSG_OFS_CORE_CLK, m ? 32'h0000_0170 : 0);
			wr(`CSG_OFS_OSC_CTRL, 32'h0000_00ab);
			sleep_mode <= 1'b1;
			repeat (4) @(posedge pclk);
			rdc(`CSG_OFS_SRC_STATE, 32'h0000_0111);
			sleep_mode <= 1'b0;
			repeat (4) @(posedge pclk);
			rdc(`CSG_OFS_SRC_STATE, m ? 32'h0000_009b : 32'h0000_0011);
		end
		mdl[`CSG_OFS_CORE_CLK] = 32'h0000_0177;
		rdc(`CSG_OFS_CORE_CLK, mdl[`CSG_OFS_CORE_CLK]);
		$display("sleep test done");
		// Clock output divides the internal oscillator and rests low when off
		// The pin counts as assigned to the generator before it is enabled
		// Core now runs from the external input halved after the wake switch
		for (int d = 0; d < 3; d++) begin
			wr(`CSG_OFS_CLK_OUT_CTRL, 32'h0000_0020 | (d << 2));
			watch(64);
			chk(n, 32 >> d);
			chk(nc, 16);
		end
		wr(`CSG_OFS_CLK_OUT_CTRL, 32'h0000_0008);
		repeat (3) @(posedge pclk);
		watch(20);
		chk(n, 0);
		chk(clock_output_pin_reg, 0);
		$display("clock output test done");
		print_verdict();
	end
endmodule // test_csg_clock_source_generator
`default_nettype wire
